// ---- hdl/siu_pkg.sv ----
// Purpose: Constants and types for the system instruction unit
// Assumes: One instruction is offered per cycle with a valid strobe
// Notes:   Operation
// Operation
// - Move-from-special copies selected special register; interrupt and execution status views read zero.
// - Reading the base-priority-raise name returns the base priority mask.
// - Unprivileged move-to-special reaches only application status; privileged reaches all.
// - Unprivileged writes to unallocated or execution-state bits are discarded.
// - Raise write updates base mask only if nonzero and mask zero or smaller.
// - Flags, ge, or both selectors accepted; bare name means flags selector.
// - Application flags are set directly from source register bits.
// - No-operation has no effect and costs no cycle.
// - Send-event broadcasts an event and sets the local event register.
// - Supervisor-call raises its exception; the 8-bit immediate is not interpreted.
// - Wait-for-event with event register set clears it and continues.
// - Wait-for-event with event clear sleeps until exception, pend, debug or event.
// - Wait-for-interrupt sleeps until taken interrupt, masked pend or debug request.
// - All accept a condition; only move-to-special alters the flags.
package siu_pkg;
   typedef enum logic [3:0] {
      SIU_OP_NOP, SIU_OP_MOVE_FROM, SIU_OP_MOVE_TO, SIU_OP_SEND_EVT, SIU_OP_SUP_CALL,
      SIU_OP_WAIT_EVT, SIU_OP_WAIT_INT, SIU_OP_OTHER
   } siu_op_t;

   typedef enum logic [3:0] {
      SIU_SR_APP, SIU_SR_INT, SIU_SR_EXEC, SIU_SR_INT_EXEC, SIU_SR_INT_APP,
      SIU_SR_EXEC_APP, SIU_SR_PROG_STAT, SIU_SR_MAIN_SP, SIU_SR_PROC_SP, SIU_SR_ALL_PRIO,
      SIU_SR_BASE_PRIO, SIU_SR_BASE_RAISE, SIU_SR_FAULT_PRIO, SIU_SR_CONTROL,
      SIU_SR_APP_GE, SIU_SR_APP_FLAGS_GE
   } siu_sreg_t;

   typedef struct packed {
      siu_op_t   op;
      siu_sreg_t sreg;
      logic      condPass;
      logic [7:0] imm;
      logic [31:0] srcGpr;
   } siu_instr_t;

   typedef struct packed {
      logic excPending;
      logic excUnmasked;
      logic intTaken;
      logic intPrimaskPend;
      logic debugReq;
      logic debugEn;
      logic extEvent;
      logic sendEventOnPend;
   } siu_wake_t;

   localparam int          SIU_FLAGS_LSB = 27;
   localparam int          SIU_GE_LSB    = 16;
   localparam logic [31:0] SIU_FLAGS_MSK = 32'hf800_0000;
   localparam logic [31:0] SIU_GE_MSK    = 32'h000f_0000;
   localparam logic [7:0]  SIU_PRI_RST   = 8'h00;
   localparam logic [31:0] SIU_WORD_RST  = 32'h0000_0000;
   localparam logic [1:0]  SIU_CTRL_RST  = 2'h0;
endpackage

// ---- hdl/system_instruction_unit.sv ----
// Purpose: Executes move-special, hint, event, wait and supervisor-call operations
// Assumes: Decoder supplies selector, condition result and source operand
// Notes:   Wake inputs come from the same clock domain
`timescale 1ns/1ps
module system_instruction_unit
   import siu_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        reset_n,
   input  wire logic        instrValid,
   input  wire siu_instr_t  instr,
   input  wire logic        privileged,
   input  wire siu_wake_t   wake,
   output logic             instrReady,
   output logic [31:0]      rdData,
   output logic             rdValid,
   output logic [31:0]      appStatus,
   output logic [31:0]      mainStackPtr,
   output logic [31:0]      procStackPtr,
   output logic             allPrioMask,
   output logic [7:0]       basePrioMask,
   output logic             faultPrioMask,
   output logic [1:0]       control,
   output logic             eventReg,
   output logic             eventBroadcast,
   output logic             supCallRaise,
   output logic [7:0]       supCallImm,
   output logic             sleeping
);
   typedef enum logic {SIU_RUN, SIU_SLEEP} siu_state_t;
   siu_state_t state_ff;
   logic       waitInt_ff, ready_ff, sleep_ff;
   logic [31:0] appStatus_ff, mainSp_ff, procSp_ff, rdData_ff, nxt_app;
   logic [7:0]  supImm_ff, base_priority_mask_ff;
   logic        prim_ff, fault_ff, event_ff, rdValid_ff, bcast_ff, supCall_ff;
   logic [1:0]  ctrl_ff;

   wire logic run        = (state_ff == SIU_RUN);
   wire logic go         = instrValid && run && instr.condPass;
   wire logic isMoveFrom = go && instr.op == SIU_OP_MOVE_FROM;
   wire logic isMoveTo   = go && instr.op == SIU_OP_MOVE_TO;
   wire logic isSendEvt  = go && instr.op == SIU_OP_SEND_EVT;
   wire logic isSupCall  = go && instr.op == SIU_OP_SUP_CALL;
   wire logic isWaitEvt  = go && instr.op == SIU_OP_WAIT_EVT;
   wire logic isWaitInt  = go && instr.op == SIU_OP_WAIT_INT;
   wire logic [7:0] src8 = instr.srcGpr[7:0];
   // Application selectors are open to everyone, the rest need privilege
   wire logic appSel = instr.sreg == SIU_SR_APP || instr.sreg == SIU_SR_APP_GE ||
                       instr.sreg == SIU_SR_APP_FLAGS_GE;
   wire logic wrOk   = isMoveTo && (appSel || privileged);
   wire logic flagWr = instr.sreg == SIU_SR_APP || instr.sreg == SIU_SR_APP_FLAGS_GE;
   wire logic geWr   = instr.sreg == SIU_SR_APP_GE || instr.sreg == SIU_SR_APP_FLAGS_GE;
   wire logic raiseOk = src8 != 8'h00 &&
                        (base_priority_mask_ff == 8'h00 || src8 < base_priority_mask_ff);
   wire logic wakeEvt = wake.excUnmasked || (wake.excPending && wake.sendEventOnPend) ||
                        (wake.debugReq && wake.debugEn) || wake.extEvent;
   wire logic wakeInt = wake.intTaken || wake.intPrimaskPend || wake.debugReq;
   wire logic wakeNow = waitInt_ff ? wakeInt : wakeEvt;

   // Only allocated flag bits are written, the rest stay zero
   always_comb begin
      nxt_app = appStatus_ff;
      if (wrOk && flagWr) begin
         nxt_app = (nxt_app & ~SIU_FLAGS_MSK) | (instr.srcGpr & SIU_FLAGS_MSK);
      end
      if (wrOk && geWr) begin
         nxt_app = (nxt_app & ~SIU_GE_MSK) | (instr.srcGpr & SIU_GE_MSK);
      end
   end

   function automatic logic [31:0] rd_sel(input siu_sreg_t s);
      case (s)
         SIU_SR_APP, SIU_SR_INT_APP, SIU_SR_EXEC_APP, SIU_SR_PROG_STAT: rd_sel = appStatus_ff;
         SIU_SR_INT, SIU_SR_EXEC, SIU_SR_INT_EXEC: rd_sel = SIU_WORD_RST;
         SIU_SR_MAIN_SP:       rd_sel = mainSp_ff;
         SIU_SR_PROC_SP:       rd_sel = procSp_ff;
         SIU_SR_ALL_PRIO:      rd_sel = {31'h0, prim_ff};
         SIU_SR_BASE_PRIO, SIU_SR_BASE_RAISE: rd_sel = {24'h0, base_priority_mask_ff};
         SIU_SR_FAULT_PRIO:    rd_sel = {31'h0, fault_ff};
         SIU_SR_CONTROL:       rd_sel = {30'h0, ctrl_ff};
         default:              rd_sel = SIU_WORD_RST;
      endcase
   endfunction

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= SIU_RUN;
         waitInt_ff <= 1'b0;
         ready_ff <= 1'b1;
         sleep_ff <= 1'b0;
         appStatus_ff <= SIU_WORD_RST;
         mainSp_ff <= SIU_WORD_RST;
         procSp_ff <= SIU_WORD_RST;
         prim_ff <= 1'b0;
         fault_ff <= 1'b0;
         base_priority_mask_ff <= SIU_PRI_RST;
         ctrl_ff <= SIU_CTRL_RST;
      end else begin
         appStatus_ff <= nxt_app;
         if (wrOk && instr.sreg == SIU_SR_MAIN_SP) mainSp_ff <= instr.srcGpr;
         if (wrOk && instr.sreg == SIU_SR_PROC_SP) procSp_ff <= instr.srcGpr;
         if (wrOk && instr.sreg == SIU_SR_ALL_PRIO) prim_ff <= instr.srcGpr[0];
         if (wrOk && instr.sreg == SIU_SR_FAULT_PRIO) fault_ff <= instr.srcGpr[0];
         if (wrOk && instr.sreg == SIU_SR_CONTROL) ctrl_ff <= instr.srcGpr[1:0];
         if (wrOk && instr.sreg == SIU_SR_BASE_PRIO) base_priority_mask_ff <= src8;
         if (wrOk && instr.sreg == SIU_SR_BASE_RAISE && raiseOk) base_priority_mask_ff <= src8;
         case (state_ff)
            SIU_RUN: begin
               if ((isWaitEvt && !event_ff) || isWaitInt) begin
                  state_ff <= SIU_SLEEP;
                  waitInt_ff <= isWaitInt;
                  ready_ff <= 1'b0;
                  sleep_ff <= 1'b1;
               end
            end
            SIU_SLEEP: begin
               if (wakeNow) begin
                  state_ff <= SIU_RUN;
                  ready_ff <= 1'b1;
                  sleep_ff <= 1'b0;
               end
            end
            default: state_ff <= SIU_RUN;
         endcase
      end
   end

   // Event register: send-event sets, a consuming wait clears, an external event sets
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         event_ff <= 1'b0;
      end else if (isSendEvt || wake.extEvent) begin
         event_ff <= 1'b1;
      end else if (isWaitEvt && event_ff) begin
         event_ff <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rdData_ff <= SIU_WORD_RST;
         rdValid_ff <= 1'b0;
         bcast_ff <= 1'b0;
         supCall_ff <= 1'b0;
         supImm_ff <= 8'h00;
      end else begin
         rdValid_ff <= isMoveFrom;
         if (isMoveFrom) rdData_ff <= rd_sel(instr.sreg);
         bcast_ff <= isSendEvt;
         supCall_ff <= isSupCall;
         if (isSupCall) supImm_ff <= instr.imm;
      end
   end

   // A no-operation simply retires in the cycle it is offered
   assign instrReady     = ready_ff;
   assign rdData         = rdData_ff;
   assign rdValid        = rdValid_ff;
   assign appStatus      = appStatus_ff;
   assign mainStackPtr   = mainSp_ff;
   assign procStackPtr   = procSp_ff;
   assign allPrioMask    = prim_ff;
   assign basePrioMask   = base_priority_mask_ff;
   assign faultPrioMask  = fault_ff;
   assign control        = ctrl_ff;
   assign eventReg       = event_ff;
   assign eventBroadcast = bcast_ff;
   assign supCallRaise   = supCall_ff;
   assign supCallImm     = supImm_ff;
   assign sleeping       = sleep_ff;

   property p_raise_rule;
      @(posedge mclk) disable iff (!reset_n)
      (wrOk && instr.sreg == SIU_SR_BASE_RAISE && !raiseOk) |=> $stable(base_priority_mask_ff);
   endproperty
   a_raise_rule: assert property (p_raise_rule) else $error("raise changed mask");

   property p_unpriv;
      @(posedge mclk) disable iff (!reset_n)
      (isMoveTo && !privileged && instr.sreg == SIU_SR_MAIN_SP) |=> $stable(mainSp_ff);
   endproperty
   a_unpriv: assert property (p_unpriv) else $error("unprivileged write landed");

   property p_status_zero;
      @(posedge mclk) disable iff (!reset_n)
      (isMoveFrom && instr.sreg == SIU_SR_INT) |=> rdValid && rdData == 32'h0;
   endproperty
   a_status_zero: assert property (p_status_zero) else $error("status view not zero");

   property p_alias;
      @(posedge mclk) disable iff (!reset_n)
      (isMoveFrom && instr.sreg == SIU_SR_BASE_RAISE) |=> rdData == {24'h0, base_priority_mask_ff};
   endproperty
   a_alias: assert property (p_alias) else $error("alias read wrong");

   property p_sev;
      @(posedge mclk) disable iff (!reset_n)
      isSendEvt |=> eventReg && eventBroadcast;
   endproperty
   a_sev: assert property (p_sev) else $error("send event missing");

   property p_evt_skip;
      @(posedge mclk) disable iff (!reset_n)
      (isWaitEvt && event_ff && !wake.extEvent) |=> !eventReg && !sleeping;
   endproperty
   a_evt_skip: assert property (p_evt_skip) else $error("event wait kept event");

   property p_int_wake;
      @(posedge mclk) disable iff (!reset_n)
      (sleeping && waitInt_ff && wake.intTaken) |=> !sleeping;
   endproperty
   a_int_wake: assert property (p_int_wake) else $error("interrupt wait stuck");

   property p_evt_wake;
      @(posedge mclk) disable iff (!reset_n)
      (sleeping && !waitInt_ff && wake.extEvent) |=> !sleeping;
   endproperty
   a_evt_wake: assert property (p_evt_wake) else $error("event wait stuck");

   property p_flags_only_move;
      @(posedge mclk) disable iff (!reset_n)
      !isMoveTo |=> $stable(appStatus_ff);
   endproperty
   a_flags_only_move: assert property (p_flags_only_move) else $error("flags changed");

   property p_sup_call;
      @(posedge mclk) disable iff (!reset_n)
      isSupCall |=> supCallRaise && supCallImm == $past(instr.imm);
   endproperty
   a_sup_call: assert property (p_sup_call) else $error("call not raised");
endmodule // system_instruction_unit

// ---- bench/testbench.sv ----
// Purpose: Self-checking bench for the system instruction unit
// Assumes: Answers and register updates show just after the taking edge
// Notes:   A reference model holds every special register, the event flag and sleep state
`timescale 1ns/1ps
module testbench import siu_pkg::*;;
   logic        mclk       = 1'b0;
   logic        reset_n    = 1'b0;
   logic        instrValid = 1'b0;
   logic        privileged = 1'b1;
   siu_instr_t  instr      = '0;
   siu_wake_t   wake       = '0;
   logic        instrReady, rdValid, allPrioMask, faultPrioMask, eventReg;
   logic        eventBroadcast, supCallRaise, sleeping;
   logic [31:0] rdData, appStatus, mainStackPtr, procStackPtr;
   logic [7:0]  basePrioMask, supCallImm;
   logic [1:0]  control;
   logic [31:0] mApp, mMainSp, mProcSp, mRd, rnd;
   logic [7:0]  mBp, mImm;
   logic [1:0]  mCtl;
   logic        mPm, mFm, mEv, mSlp, mRdV, mBc, mSup;
   logic [7:0]  raiseVal [6] = '{8'h00, 8'h40, 8'h40, 8'h60, 8'h3f, 8'h01};
   logic [7:0]  evtWake [4] = '{8'h40, 8'h81, 8'h0c, 8'h02};
   logic [7:0]  intWake [3] = '{8'h20, 8'h10, 8'h08};
   siu_sreg_t   appSel [3] = '{SIU_SR_APP, SIU_SR_APP_GE, SIU_SR_APP_FLAGS_GE};
   int          mismatches = 0;
   int          cmp_count  = 0;
   int          cycles     = 0;

   system_instruction_unit uut (.mclk(mclk), .reset_n(reset_n), .instrValid(instrValid),
      .instr(instr), .privileged(privileged), .wake(wake), .instrReady(instrReady),
      .rdData(rdData), .rdValid(rdValid), .appStatus(appStatus), .mainStackPtr(mainStackPtr),
      .procStackPtr(procStackPtr), .allPrioMask(allPrioMask), .basePrioMask(basePrioMask),
      .faultPrioMask(faultPrioMask), .control(control), .eventReg(eventReg),
      .eventBroadcast(eventBroadcast), .supCallRaise(supCallRaise), .supCallImm(supCallImm),
      .sleeping(sleeping));

   always #5 mclk = ~mclk;

   // Cuts a hang short well beyond the roughly 155 cycles the sequence needs
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         complete_run();
      end
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [31:0] sel(input siu_sreg_t s);
      case (s)
         SIU_SR_INT, SIU_SR_EXEC, SIU_SR_INT_EXEC: return 32'h0;
         SIU_SR_MAIN_SP:                           return mMainSp;
         SIU_SR_PROC_SP:                           return mProcSp;
         SIU_SR_ALL_PRIO:                          return {31'h0, mPm};
         SIU_SR_BASE_PRIO, SIU_SR_BASE_RAISE:      return {24'h0, mBp};
         SIU_SR_FAULT_PRIO:                        return {31'h0, mFm};
         SIU_SR_CONTROL:                           return {30'h0, mCtl};
         default:                                  return mApp;
      endcase
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic chk_all();
      chk({31'h0, rdValid}, {31'h0, mRdV});
      if (mRdV) chk(rdData, mRd);
      chk(appStatus, mApp);
      chk(mainStackPtr, mMainSp);
      chk(procStackPtr, mProcSp);
      chk({20'h0, allPrioMask, faultPrioMask, control, basePrioMask},
          {20'h0, mPm, mFm, mCtl, mBp});
      chk({30'h0, eventReg, eventBroadcast}, {30'h0, mEv, mBc});
      chk({29'h0, supCallRaise, sleeping, instrReady},
          {29'h0, mSup, mSlp, ~mSlp});
      if (mSup) chk({24'h0, supCallImm}, {24'h0, mImm});
   endtask

   task automatic issue(input siu_op_t op, input siu_sreg_t s, input logic cp,
                        input logic [31:0] src);
      logic [7:0] b;
      b = src[7:0];
      @(posedge mclk);
      #1;
      instrValid = 1'b1;
      instr = '{op, s, cp, b, src}; // Operands are always ordinary registers
      @(posedge mclk);
      #1;
      instrValid = 1'b0;
      {mRdV, mBc, mSup} = 3'h0;
      if (cp && !mSlp) case (op)
         SIU_OP_MOVE_FROM: {mRdV, mRd} = {1'b1, sel(s)};
         SIU_OP_MOVE_TO: begin
            if (s == SIU_SR_APP || s == SIU_SR_APP_FLAGS_GE)
               mApp = (mApp & ~SIU_FLAGS_MSK) | (src & SIU_FLAGS_MSK);
            if (s == SIU_SR_APP_GE || s == SIU_SR_APP_FLAGS_GE)
               mApp = (mApp & ~SIU_GE_MSK) | (src & SIU_GE_MSK);
            if (privileged) case (s)
               SIU_SR_MAIN_SP:       mMainSp = src;
               SIU_SR_PROC_SP:       mProcSp = src;
               SIU_SR_ALL_PRIO:      mPm = src[0];
               SIU_SR_FAULT_PRIO:    mFm = src[0];
               SIU_SR_CONTROL:       mCtl = src[1:0];
               SIU_SR_BASE_PRIO:     mBp = b;
               SIU_SR_BASE_RAISE:    if (b != 8'h0 && (mBp == 8'h0 || b < mBp)) mBp = b;
               default: ;
            endcase
         end
         SIU_OP_SEND_EVT: {mBc, mEv} = 2'h3;
         SIU_OP_SUP_CALL: {mSup, mImm} = {1'b1, b};
         SIU_OP_WAIT_EVT: if (mEv) mEv = 1'b0; else mSlp = 1'b1;
         SIU_OP_WAIT_INT: mSlp = 1'b1;
         default: ;
      endcase
      chk_all();
   endtask

   task automatic wk(input logic [7:0] w, input logic wakes);
      @(posedge mclk);
      #1;
      wake = siu_wake_t'(w);
      @(posedge mclk);
      #1;
      wake = '0;
      if (wakes) mSlp = 1'b0;
      if (w[1]) mEv = 1'b1;
      chk_all();
   endtask

   task automatic complete_run();
      $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   initial begin
      {mApp, mMainSp, mProcSp, mRd, mBp, mImm, mCtl} = '0;
      {mPm, mFm, mEv, mSlp, mRdV, mBc, mSup} = '0;
      rnd = 32'h0000_0014;
      repeat (3) @(posedge mclk);
      #1;
      reset_n = 1'b1;
      chk_all();
      for (int i = 7; i <= 13; i++) begin
         rnd = lfsr(rnd);
         issue(SIU_OP_MOVE_TO, siu_sreg_t'(i), 1'b1, rnd);
      end
      issue(SIU_OP_MOVE_TO, SIU_SR_BASE_PRIO, 1'b1, 32'h0);
      foreach (raiseVal[i])
         issue(SIU_OP_MOVE_TO, SIU_SR_BASE_RAISE, 1'b1, {24'h0, raiseVal[i]});
      foreach (appSel[i]) begin
         rnd = lfsr(rnd);
         issue(SIU_OP_MOVE_TO, appSel[i], 1'b1, rnd);
      end
      for (int i = 0; i <= 13; i++) issue(SIU_OP_MOVE_FROM, siu_sreg_t'(i), 1'b1, rnd);
      privileged = 1'b0;
      for (int i = 7; i <= 13; i++) issue(SIU_OP_MOVE_TO, siu_sreg_t'(i), 1'b1, 32'h0000_0002);
      issue(SIU_OP_MOVE_TO, SIU_SR_APP_FLAGS_GE, 1'b1, 32'hffff_ffff);
      issue(SIU_OP_MOVE_FROM, SIU_SR_PROG_STAT, 1'b1, 32'h0);
      privileged = 1'b1;
      issue(SIU_OP_SEND_EVT, SIU_SR_APP, 1'b0, 32'h0);
      issue(SIU_OP_MOVE_TO, SIU_SR_APP, 1'b0, 32'h0);
      issue(SIU_OP_NOP, SIU_SR_APP, 1'b1, 32'hffff_ffff);
      issue(SIU_OP_SUP_CALL, SIU_SR_APP, 1'b1, 32'h0000_00ff);
      issue(SIU_OP_SUP_CALL, SIU_SR_APP, 1'b1, 32'h0);
      issue(SIU_OP_SEND_EVT, SIU_SR_APP, 1'b1, 32'h0);
      issue(SIU_OP_WAIT_EVT, SIU_SR_APP, 1'b1, 32'h0);
      foreach (evtWake[i]) begin
         issue(SIU_OP_WAIT_EVT, SIU_SR_APP, 1'b1, 32'h0);
         wk(8'h80, 1'b0);
         wk(8'h08, 1'b0);
         issue(SIU_OP_SEND_EVT, SIU_SR_APP, 1'b1, 32'h0);
         wk(evtWake[i], 1'b1);
      end
      foreach (intWake[i]) begin
         issue(SIU_OP_WAIT_INT, SIU_SR_APP, 1'b1, 32'h0);
         wk(8'h02, 1'b0);
         wk(intWake[i], 1'b1);
      end
      complete_run();
   end
endmodule // testbench
